// file: rtl/ssi_sync_serial_iface.sv
// synchronous character serial line interface: processor port, serializer, deserializer
`timescale 1ns/1ps
module ssi_sync_serial_iface import ssi_pkg::*; #(
	parameter int DISC_CYCLES = DISC_CYC,
	parameter logic [7:0] MY_ADDR = DEV_ADDR
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire ssi_io_s io,
	input wire ssi_line_s line,
	output logic [7:0] io_din_r,
	output logic io_ack_r,
	output logic wr_ready,
	output logic irq_r,
	output logic txd_r,
	output logic rts_r,
	output logic dtr_r
);
	ssi_line_s ln1_r, ln2_r, ln3_r;
	logic hit, cmd_hit, sts_hit, wd_hit, rd_hit;
	logic fifo_valid, tx_pop;
	logic [7:0] fifo_data;
	// tx / rx group
	logic txd_nxt;
	logic [7:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt, rx_data_r, rx_data_nxt, tx_word;
	logic [2:0] tx_bit_r, tx_bit_nxt, rx_bit_r, rx_bit_nxt;
	ssi_rx_e rx_st_r, rx_st_nxt;
	logic rx_full_r, rx_full_nxt;
	logic tx_run, tx_fall, tx_load, underrun, tx_par;
	logic rx_rise, rx_pok, rx_syn, rx_done, deliver;
	logic [7:0] rx_new;
	// control / flag group
	logic wrt_r, wrt_nxt, ssch_r, ssch_nxt, pm_r, pm_nxt, read_r, read_nxt;
	logic pend_r, pend_nxt, ien_r, ien_nxt, dtren_r, dtren_nxt;
	logic ov_r, ov_nxt, pf_r, pf_nxt, sync_r, sync_nxt, irq_q_r, irq_q_nxt;
	logic busy_r, cof_r, du_r, ring_r, busy_now, cof_now, ring_now, du_now;
	logic ov_set, pf_set, sync_set, sync_clr, disc_end, event_any;
	logic [31:0] disc_r, disc_nxt;
	logic [7:0] status, din_nxt;

	// link bit clocks and levels come from the far end's timing source
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ln1_r <= LINE_IDLE;
			ln2_r <= LINE_IDLE;
			ln3_r <= LINE_IDLE;
		end else begin
			ln1_r <= line;
			ln2_r <= ln1_r;
			ln3_r <= ln2_r;
		end
	end

	assign hit = (io.addr == MY_ADDR);
	assign cmd_hit = io.cmd & hit;
	assign sts_hit = io.sts & hit;
	assign wd_hit = io.wd & hit;
	assign rd_hit = io.rd & hit;

	ssi_buf2 #(.WIDTH(8), .DEPTH(2)) u_txbuf (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(wd_hit),
		.in_data(io.dout),
		.in_ready(wr_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(tx_pop)
	);

	// serializer: bit rate is whatever the far end clocks, nothing local
	assign tx_run = wrt_r & ssch_r & ln2_r.cts;
	assign tx_fall = ln3_r.txc & ~ln2_r.txc;
	assign tx_load = tx_fall & tx_run & (tx_bit_r == FIRST_BIT);
	assign tx_pop = tx_load & fifo_valid;
	assign underrun = tx_load & ~fifo_valid;
	assign tx_par = pm_r ? ~^tx_word[6:0] : ^tx_word[6:0];

	always_comb begin
		tx_word = fifo_valid ? fifo_data : NUL_CHAR;
	end

	// deserializer, lsb first, parity bit last
	assign rx_rise = ~ln3_r.rxc & ln2_r.rxc;
	assign rx_new = {ln2_r.rxd, rx_sh_r[7:1]};
	assign rx_pok = ((^rx_new) == pm_r);
	assign rx_syn = (rx_new[6:0] == SYN_CODE) & rx_pok;
	assign rx_done = rx_rise & rx_st_r[1] & (rx_bit_r == LAST_BIT);
	assign deliver = rx_done & (rx_st_r == RX_DATA);

	always_comb begin
		txd_nxt = txd_r;
		tx_sh_nxt = tx_sh_r;
		tx_bit_nxt = tx_bit_r;
		if (tx_fall && tx_bit_r != FIRST_BIT) begin
			txd_nxt = tx_sh_r[0];
			tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
			tx_bit_nxt = 3'(tx_bit_r + 1'b1);
		end else if (tx_load) begin
			// next character starts on the edge after the last bit: no gap
			txd_nxt = tx_word[0];
			tx_sh_nxt = {1'b0, tx_par, tx_word[6:1]};
			tx_bit_nxt = 3'(FIRST_BIT + 1'b1);
		end else if (!tx_run && tx_bit_r == FIRST_BIT) begin
			txd_nxt = MARK;
		end
		rx_sh_nxt = rx_rise ? rx_new : rx_sh_r;
		rx_bit_nxt = rx_bit_r;
		rx_st_nxt = rx_st_r;
		if (rx_rise && rx_st_r[1]) begin
			rx_bit_nxt = 3'(rx_bit_r + 1'b1);
		end
		case (rx_st_r)
			RX_OFF: rx_st_nxt = RX_OFF;
			RX_HUNT: begin
				if (rx_rise && rx_syn) begin
					rx_st_nxt = RX_ONE;
					rx_bit_nxt = FIRST_BIT;
				end
			end
			RX_ONE: begin
				if (rx_done) begin
					rx_st_nxt = rx_syn ? RX_DATA : RX_HUNT;
				end
			end
			RX_DATA: rx_st_nxt = RX_DATA;
			default: rx_st_nxt = RX_OFF;
		endcase
		if (cmd_hit && io.dout[CM_READ]) begin
			rx_st_nxt = io.dout[CM_SSCH] ? RX_HUNT : RX_DATA;
			rx_bit_nxt = FIRST_BIT;
		end
		if (!read_nxt) begin
			rx_st_nxt = RX_OFF;
		end
		rx_data_nxt = deliver ? {1'b0, rx_new[6:0]} : rx_data_r;
		rx_full_nxt = deliver | (rx_full_r & ~rd_hit);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			txd_r <= MARK;
			tx_sh_r <= '0;
			tx_bit_r <= FIRST_BIT;
			rx_sh_r <= '0;
			rx_bit_r <= FIRST_BIT;
			rx_st_r <= RX_OFF;
			rx_data_r <= '0;
			rx_full_r <= 1'b0;
		end else begin
			txd_r <= txd_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_bit_r <= tx_bit_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_st_r <= rx_st_nxt;
			rx_data_r <= rx_data_nxt;
			rx_full_r <= rx_full_nxt;
		end
	end

	// flags and modem levels
	assign busy_now = (wrt_r & ~ln2_r.cts) | (tx_bit_r != FIRST_BIT) | (disc_r != '0);
	assign cof_now = ~ln2_r.dcd & ~rts_r;
	assign ring_now = ln2_r.ri;
	assign du_now = ~ln2_r.dsr;
	assign ov_set = underrun | (deliver & rx_full_r & ~rd_hit);
	assign pf_set = rx_done & ~rx_pok;
	assign sync_set = (rx_rise & rx_syn & (rx_st_r == RX_HUNT)) | (rx_done & rx_syn);
	assign sync_clr = rx_done & ~rx_syn;
	assign disc_end = (disc_r == 32'h0000_0001);
	assign event_any = (ov_set & ~ov_r) | (pf_set & ~pf_r) | (sync_set & ~sync_r)
		| (ring_now & ~ring_r) | (busy_r & ~busy_now) | (cof_now ^ cof_r)
		| (du_now & ~du_r) | disc_end;

	always_comb begin
		status = '0;
		status[ST_OV] = ov_r;
		status[ST_PF] = pf_r;
		status[ST_SYNC] = sync_r;
		status[ST_RING] = ring_now;
		status[ST_BUSY] = busy_now;
		status[ST_EX] = ov_r | pf_r | ring_now;
		status[ST_COF] = cof_now;
		status[ST_DU] = du_now;
	end

	always_comb begin
		wrt_nxt = wrt_r;
		ssch_nxt = ssch_r;
		pm_nxt = pm_r;
		read_nxt = read_r;
		pend_nxt = pend_r;
		ien_nxt = ien_r;
		dtren_nxt = dtren_r;
		disc_nxt = (disc_r != '0) ? 32'(disc_r - 1'b1) : disc_r;
		if (cmd_hit) begin
			wrt_nxt = io.dout[CM_WRT];
			ssch_nxt = io.dout[CM_SSCH];
			pm_nxt = io.dout[CM_PM];
			dtren_nxt = io.dout[CM_DTR];
			if (io.dout[CM_IRQ_DISABLE_BIT]) begin
				ien_nxt = 1'b0;
			end
			if (io.dout[CM_IRQ_ENABLE_BIT]) begin
				ien_nxt = 1'b1;
			end
			if (io.dout[CM_READ]) begin
				read_nxt = 1'b1;
				pend_nxt = 1'b0;
			end else if (read_r && tx_bit_r != FIRST_BIT) begin
				pend_nxt = 1'b1;
			end else begin
				read_nxt = 1'b0;
			end
			if (io.dout[CM_HANGUP_CMD] && dtr_r) begin
				disc_nxt = 32'(DISC_CYCLES);
			end
		end else if (pend_r && tx_bit_r == FIRST_BIT) begin
			read_nxt = 1'b0;
			pend_nxt = 1'b0;
		end
		// a setting event in the clearing cycle wins
		ov_nxt = ov_set | (ov_r & ~cmd_hit);
		pf_nxt = pf_set | (pf_r & ~cmd_hit);
		sync_nxt = sync_set | (sync_r & ~cmd_hit & ~sync_clr);
		irq_q_nxt = event_any | (irq_q_r & ~sts_hit);
		din_nxt = io_din_r;
		if (sts_hit) begin
			din_nxt = status;
		end else if (rd_hit) begin
			din_nxt = rx_data_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrt_r <= CMD_RST[CM_WRT];
			ssch_r <= CMD_RST[CM_SSCH];
			pm_r <= CMD_RST[CM_PM];
			read_r <= CMD_RST[CM_READ];
			pend_r <= 1'b0;
			ien_r <= 1'b0;
			dtren_r <= CMD_RST[CM_DTR];
			disc_r <= '0;
			ov_r <= 1'b0;
			pf_r <= 1'b0;
			sync_r <= 1'b0;
			irq_q_r <= 1'b0;
			busy_r <= 1'b0;
			cof_r <= 1'b0;
			du_r <= 1'b0;
			ring_r <= 1'b0;
			io_din_r <= '0;
			io_ack_r <= 1'b0;
			irq_r <= 1'b0;
			rts_r <= 1'b0;
			dtr_r <= 1'b0;
		end else begin
			wrt_r <= wrt_nxt;
			ssch_r <= ssch_nxt;
			pm_r <= pm_nxt;
			read_r <= read_nxt;
			pend_r <= pend_nxt;
			ien_r <= ien_nxt;
			dtren_r <= dtren_nxt;
			disc_r <= disc_nxt;
			ov_r <= ov_nxt;
			pf_r <= pf_nxt;
			sync_r <= sync_nxt;
			irq_q_r <= irq_q_nxt;
			busy_r <= busy_now;
			cof_r <= cof_now;
			du_r <= du_now;
			ring_r <= ring_now;
			io_din_r <= din_nxt;
			io_ack_r <= cmd_hit | sts_hit | rd_hit | (wd_hit & wr_ready);
			irq_r <= irq_q_nxt & ien_nxt;
			rts_r <= wrt_nxt;
			// hang-up drops the terminal-ready lead for the whole count
			dtr_r <= dtren_nxt & (disc_nxt == '0);
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_rx_msb_zero: assert property (rx_full_r |-> !rx_data_r[7])
		else $error("received byte msb not zero");
	a_underrun_ov: assert property (underrun |=> ov_r)
		else $error("underrun did not set overrun");
	a_nul_sent: assert property (underrun |-> ##1 (!txd_r && tx_sh_r[5:0] == 6'h00))
		else $error("underrun character is not NUL");
	a_tx_parity: assert property (tx_load && fifo_valid |=> ^{txd_r, tx_sh_r} == pm_r)
		else $error("transmit parity wrong");
	a_rx_overwrite: assert property (deliver && rx_full_r && !rd_hit |=> ov_r)
		else $error("receive overwrite not flagged");
	a_ov_queue: assert property ($rose(ov_r) |-> irq_q_r)
		else $error("overrun did not queue interrupt");
	a_pf_set: assert property (rx_done && !rx_pok |=> pf_r ##0 irq_q_r || $past(pf_r))
		else $error("parity failure not flagged");
	a_hunt_hold: assert property ($rose(rx_full_r) |-> $past(rx_st_r) == RX_DATA)
		else $error("character passed during sync search");
	a_read_defer: assert property (cmd_hit && !io.dout[CM_READ] && read_r
		&& tx_bit_r != FIRST_BIT |=> read_r)
		else $error("read mode left mid character");
	a_sts_keep: assert property (sts_hit && !cmd_hit && ov_r |=> ov_r)
		else $error("status read cleared overrun");
	a_gapless: assert property (tx_run && tx_fall && tx_bit_r == FIRST_BIT
		|=> tx_bit_r != FIRST_BIT)
		else $error("serializer stalled between characters");
	c_underrun: cover property (underrun);
	c_synced: cover property (rx_st_r == RX_ONE ##[1:1000] rx_st_r == RX_DATA);
	c_rx_overrun: cover property (deliver && rx_full_r);
	c_hangup: cover property (disc_end);
endmodule

// file: rtl/ssi_pkg.sv
// constants, carriers and state codes for the synchronous serial line interface
package ssi_pkg;
	localparam int CLK_MHZ = 200;
	localparam int MAX_BAUD = 9600;
	localparam int DISC_MS = 150;
	localparam int DISC_CYC = DISC_MS * CLK_MHZ * 1000;
	localparam logic [7:0] DEV_ADDR = 8'h72;
	localparam logic [6:0] SYN_CODE = 7'h16;
	localparam logic [7:0] NUL_CHAR = 8'h00;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] FIRST_BIT = 3'h0;
	localparam logic MARK = 1'b1;
	// status positions: the line's bit 0 is the byte's msb
	localparam int ST_OV = 7;
	localparam int ST_PF = 6;
	localparam int ST_SYNC = 5;
	localparam int ST_RING = 4;
	localparam int ST_BUSY = 3;
	localparam int ST_EX = 2;
	localparam int ST_COF = 1;
	localparam int ST_DU = 0;
	localparam int CM_IRQ_DISABLE_BIT = 7;
	localparam int CM_IRQ_ENABLE_BIT = 6;
	localparam int CM_PM = 5;
	localparam int CM_SSCH = 4;
	localparam int CM_DTR = 3;
	localparam int CM_HANGUP_CMD = 2;
	localparam int CM_WRT = 1;
	localparam int CM_READ = 0;
	typedef struct packed {
		logic rxd;
		logic rxc;
		logic txc;
		logic cts;
		logic dcd;
		logic dsr;
		logic ri;
	} ssi_line_s;
	// pin synchronisers restart at idle levels: clocks and data high, so no false edge
	localparam ssi_line_s LINE_IDLE = 7'h72;
	typedef struct packed {
		logic [7:0] addr;
		logic cmd;
		logic sts;
		logic wd;
		logic rd;
		logic [7:0] dout;
	} ssi_io_s;
	typedef enum logic [1:0] {
		RX_OFF = 2'b00,
		RX_HUNT = 2'b01,
		RX_ONE = 2'b10,
		RX_DATA = 2'b11
	} ssi_rx_e;
endpackage

// file: rtl/ssi_buf2.sv
// small valid/ready buffer holding transmit bytes ahead of the serializer
`timescale 1ns/1ps
module ssi_buf2 import ssi_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_r[rp_r];

	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == PTR_LAST) ? '0 : AW'(wp_r + 1'b1);
		end
		if (pop) begin
			rp_nxt = (rp_r == PTR_LAST) ? '0 : AW'(rp_r + 1'b1);
		end
		if (push && !pop) begin
			cnt_nxt = CW'(cnt_r + 1'b1);
		end else if (pop && !push) begin
			cnt_nxt = CW'(cnt_r - 1'b1);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != CNT_FULL);
			out_valid <= (cnt_nxt != '0);
		end
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule

// file: tb/ssi_line_model.sv
// far-end modem model: supplies both bit clocks, sends and captures characters
`timescale 1ns/1ps
module ssi_line_model (
	output logic txc,
	output logic rxc,
	output logic rxd,
	input wire logic txd
);
	logic [7:0] got [0:3];

	// clocks stand high between frames; the far end owns all bit timing
	initial begin
		txc = 1'b1;
		rxc = 1'b1;
		rxd = 1'b1;
	end

	// lsb first, parity last; 80 ns per bit
	task send_char(input logic [7:0] c);
		for (int i = 0; i < 8; i++) begin
			rxc = 1'b0;
			rxd = c[i];
			#40;
			rxc = 1'b1;
			#40;
		end
		// released line shows the inverse so a stale level never passes for data
		rxd = ~c[7];
	endtask

	// sample on rising txc, well after the interface moved its data on the fall
	task run_tx(input int n);
		#2;
		for (int k = 0; k < n; k++) begin
			for (int i = 0; i < 8; i++) begin
				txc = 1'b0;
				#40;
				txc = 1'b1;
				got[k][i] = txd;
				#40;
			end
		end
	endtask
endmodule

// file: tb/tb_ssi_sync_serial_iface.sv
// self-checking bench for the synchronous serial line interface
`timescale 1ns/1ps
module tb_ssi_sync_serial_iface import ssi_pkg::*;;
	logic mclk = 1'b0;
	logic rst_n;
	ssi_io_s io_v;
	logic cts, dcd, dsr, ri;
	wire m_txc, m_rxc, m_rxd;
	ssi_line_s line_w;
	logic [7:0] io_din_r;
	logic io_ack_r, wr_ready, irq_r, txd_r;
	logic rts_r, dtr_r;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [31:0] rs;
	logic [7:0] q, d;
	logic [7:0] tx [0:1];

	always #2.5 mclk = ~mclk;
	assign line_w = '{rxd: m_rxd, rxc: m_rxc, txc: m_txc, cts: cts, dcd: dcd, dsr: dsr, ri: ri};

	ssi_sync_serial_iface #(.DISC_CYCLES(20)) dut_u (
		.mclk(mclk),
		.rst_n(rst_n),
		.io(io_v),
		.line(line_w),
		.io_din_r(io_din_r),
		.io_ack_r(io_ack_r),
		.wr_ready(wr_ready),
		.irq_r(irq_r),
		.txd_r(txd_r),
		.rts_r(rts_r),
		.dtr_r(dtr_r)
	);

	ssi_line_model m (.txc(m_txc), .rxc(m_rxc), .rxd(m_rxd), .txd(txd_r));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// odd parity in the msb; bad flips it
	function automatic logic [7:0] frm(input logic [6:0] v, input logic bad);
		return {~^v ^ bad, v};
	endfunction

	task end_sim;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task nextb(output logic [7:0] b);
		repeat (8) rs = lfsr(rs);
		b = rs[7:0];
	endtask

	// k: 0 command, 1 status, 2 write, 3 read
	task bus(input logic [7:0] a, input logic [1:0] k, input logic [7:0] v,
			input logic ea, output logic [7:0] r);
		ssi_io_s s;
		s = '0;
		s.addr = a;
		s.dout = v;
		s.cmd = (k == 2'h0);
		s.sts = (k == 2'h1);
		s.wd = (k == 2'h2);
		s.rd = (k == 2'h3);
		@(posedge mclk);
		io_v <= s;
		@(posedge mclk);
		io_v <= '0;
		@(negedge mclk);
		r = io_din_r;
		chk({7'h00, io_ack_r}, {7'h00, ea});
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		end_sim;
	end

	initial begin
		io_v = '0;
		cts = 1'b0;
		dcd = 1'b1;
		dsr = 1'b1;
		ri = 1'b0;
		rst_n = 1'b0;
		rs = 32'hDD65;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({7'h00, txd_r}, 8'h01);
		bus(8'h73, 2'h1, 8'h00, 1'b0, q);
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q, 8'h00);
		ri <= 1'b1;
		repeat (8) @(posedge mclk);
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q, 8'h14);
		ri <= 1'b0;
		$display("test status done");

		// read mode, sync search, odd parity
		bus(DEV_ADDR, 2'h0, 8'h31, 1'b1, q);
		m.send_char(8'h16);
		bus(DEV_ADDR, 2'h3, 8'h00, 1'b1, q);
		chk(q, 8'h00);
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q & 8'h20, 8'h20);
		m.send_char(8'h16);
		for (int k = 0; k < 3; k++) begin
			nextb(d);
			if (d[6:0] == SYN_CODE)
				d = 8'h15;
			m.send_char(frm(d[6:0], 1'b0));
			bus(DEV_ADDR, 2'h3, 8'h00, 1'b1, q);
			chk(q, {1'b0, d[6:0]});
		end
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q & 8'hE0, 8'h00);
		m.send_char(frm(7'h41, 1'b1));
		chk({7'h00, irq_r}, 8'h00);
		// enable keeps read mode without search, so timing restarts at the command
		bus(DEV_ADDR, 2'h0, 8'h61, 1'b1, q);
		repeat (2) @(posedge mclk);
		chk({7'h00, irq_r}, 8'h01);
		m.send_char(frm(7'h2A, 1'b1));
		m.send_char(frm(7'h33, 1'b0));
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q & 8'hC0, 8'hC0);
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q & 8'hC0, 8'hC0);
		$display("test receive done");

		// write mode with clear to send; buffer filled before the line runs
		cts <= 1'b1;
		bus(DEV_ADDR, 2'h0, 8'h32, 1'b1, q);
		for (int k = 0; k < 2; k++) begin
			nextb(tx[k]);
			bus(DEV_ADDR, 2'h2, tx[k], 1'b1, q);
		end
		chk({7'h00, wr_ready}, 8'h00);
		bus(DEV_ADDR, 2'h2, 8'h55, 1'b0, q);
		m.run_tx(3);
		chk(m.got[0], frm(tx[0][6:0], 1'b0));
		chk(m.got[1], frm(tx[1][6:0], 1'b0));
		chk(m.got[2], 8'h80);
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q & 8'h80, 8'h80);
		$display("test transmit done");

		// leaving read mode mid character must wait for the character to end
		bus(DEV_ADDR, 2'h0, 8'h33, 1'b1, q);
		fork
			m.run_tx(1);
			begin
				repeat (20) @(posedge mclk);
				bus(DEV_ADDR, 2'h0, 8'h32, 1'b1, q);
			end
		join
		chk(m.got[0], 8'h80);
		// rest mode holds mark and, with read mode off, can never flag overrun
		bus(DEV_ADDR, 2'h0, 8'h0A, 1'b1, q);
		chk({7'h00, rts_r}, 8'h01);
		chk({7'h00, dtr_r}, 8'h01);
		m.run_tx(1);
		chk(m.got[0], 8'hFF);
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q & 8'h80, 8'h00);
		// hang-up drops terminal ready and shows busy for the whole count
		bus(DEV_ADDR, 2'h0, 8'h0E, 1'b1, q);
		chk({7'h00, dtr_r}, 8'h00);
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q & 8'h08, 8'h08);
		repeat (25) @(posedge mclk);
		chk({7'h00, dtr_r}, 8'h01);
		bus(DEV_ADDR, 2'h1, 8'h00, 1'b1, q);
		chk(q & 8'h08, 8'h00);
		$display("test line control done");
		end_sim;
	end
endmodule
